// File: ide_host_port.sv
// How it works
// RQ1 - transfers move whole 512-byte sectors; host never asks for part of one
// RQ2 - chs sector numbers start at one; 0/0/0 is refused
// RQ3 - linear block numbers run from zero to sector count minus one
// RQ4 - sector total is c*h*s, capacity is that times 512 bytes
// RQ5 - three low address lines with chip selects pick the register
// RQ6 - eight upper address lines are driven low
// RQ7 - first chip select reaches the command block
// RQ8 - second chip select reaches the control block
// RQ9 - card is card 0 when strap grounded, card 1 when open
// RQ10 - task registers use low eight lines; data port uses all sixteen
// RQ11 - interface select strap is held low for ide mode
// RQ12 - card interrupt only when pending and enable-not bit clear
// RQ13 - hardware reset to card is held at least 25 us
// RQ14 - card drops ready to stretch an access while busy
// RQ15 - card flags wide port when data port addressed and ready
// RQ16 - card detect lines are grounded by card; host samples them
// RQ17 - activity line shows card active or second card present
// RQ18 - diagnostics line shows card passed its self test
// RQ19 - attribute select and memory write enable are driven high
// RQ20 - input acknowledge output of card is left unused
// RQ21 - five-bit access code from selects and address, strobe marks direction
// RQ22 - status read clears interrupt, alternate status read does not
// RQ23 - sector count zero means 256 sectors
// RQ24 - reads use read strobe, writes use write strobe
// RQ25 - strobe held until card ready is high again
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ide_host_port import ide_host_pkg::*; (
    input wire logic clk_in,
    input wire logic nrst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // card pins
    output logic [2:0] register_select_lines_out,
    output logic [7:0] upper_unused_address_lines_out,
    output logic command_group_select_n_out,
    output logic control_group_select_n_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    input wire logic [15:0] card_data_lines_in,
    output logic [15:0] card_data_lines_out,
    output logic card_data_lines_oe_out,
    input wire logic card_ready_wait_in,
    input wire logic wide_port_indication_n_in,
    input wire logic card_interrupt_request_in,
    input wire logic card_detect_first_n_in,
    input wire logic card_detect_second_n_in,
    input wire logic diagnostics_passed_line_n_in,
    input wire logic activity_second_present_line_n_in,
    output logic card_reset_n_out,
    output logic interface_select_strap_out,
    output logic drive_position_strap_out,
    output logic attribute_select_n_out,
    output logic memory_write_enable_n_out
);
    typedef enum {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_RESET
    } phase_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        phase_t phase;
        logic [15:0] count;
        logic [4:0] code;
        logic is_write;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic bad_addr;
        logic [27:0] linear_block_number;
        logic [15:0] cyl;
        logic [7:0] heads;
        logic [7:0] spt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] sel;
        logic cmd_n;
        logic ctl_n;
        logic rd_n;
        logic wr_n;
        logic [15:0] dout;
        logic doe;
        logic card_rst_n;
    } host_state_t;

    host_state_t s_reg;
    host_state_t s_next;
    logic rst_n;
    logic ready_s;
    logic wide_s;
    logic irq_s;
    logic cd1_s;
    logic cd2_s;
    logic diag_s;
    logic activity_second_present_line_s;
    logic [15:0] data_s;
    logic [31:0] total_sectors;
    logic [31:0] cap_kbytes;

    assign rst_n = s_reg.rst_sync[1];

    // pin inputs pass two flip-flops before use
    ide_sync #(.WIDTH(23)) pin_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .async_in({card_ready_wait_in, wide_port_indication_n_in, card_interrupt_request_in,
                   card_detect_first_n_in, card_detect_second_n_in,
                   diagnostics_passed_line_n_in, activity_second_present_line_n_in,
                   card_data_lines_in}),
        .sync_out({ready_s, wide_s, irq_s, cd1_s, cd2_s, diag_s, activity_second_present_line_s, data_s})
    );

    ide_geometry geom (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .cyl_in(s_reg.cyl),
        .heads_in(s_reg.heads),
        .spt_in(s_reg.spt),
        .sectors_out(total_sectors),
        .kbytes_out(cap_kbytes)
    );

    // the card's input acknowledge output stays unconnected; no port takes it in: RQ20

    // next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        // apb access phase: answer one cycle after enable seen
        if (psel_in && penable_in && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.prdata = ZERO32;
            if (pwrite_in) begin
                case (paddr_in)
                    CTRL_OFF: begin
                        if (s_reg.phase != ST_IDLE) begin
                            s_next.pslverr = 1'b1;
                        end else if (pwdata_in[CTRL_RESET_BIT]) begin
                            s_next.phase = ST_RESET;
                            s_next.count = 16'(RESET_HOLD_CYCLES); // RQ13
                            s_next.card_rst_n = 1'b0; // RQ13
                        end else if (pwdata_in[CTRL_GO_BIT]) begin
                            s_next.phase = ST_SETUP;
                            s_next.count = 16'(SETUP_CYCLES);
                            s_next.is_write = pwdata_in[CTRL_WRITE_BIT];
                        end
                    end
                    ADDR_OFF: begin
                        // access code as pin levels: bit4 control select_n, bit3 command select_n
                        s_next.code = pwdata_in[4:0]; // RQ21
                    end
                    WDATA_OFF: begin
                        s_next.wdata = pwdata_in[15:0];
                    end
                    LBA_OFF: begin
                        s_next.linear_block_number = pwdata_in[27:0]; // RQ3
                    end
                    GEOM_OFF: begin
                        s_next.cyl = pwdata_in[15:0];
                        s_next.heads = pwdata_in[23:16];
                        s_next.spt = pwdata_in[31:24];
                    end
                    default: begin
                        s_next.pslverr = 1'b1;
                    end
                endcase
            end else begin
                case (paddr_in)
                    CTRL_OFF: s_next.prdata = {27'h0, s_reg.code};
                    ADDR_OFF: s_next.prdata = {27'h0, s_reg.code};
                    WDATA_OFF: s_next.prdata = {16'h0, s_reg.wdata};
                    RDATA_OFF: s_next.prdata = {16'h0, s_reg.rdata};
                    STATUS_OFF: begin
                        s_next.prdata[ST_BUSY_BIT] = (s_reg.phase != ST_IDLE);
                        s_next.prdata[ST_PRESENT_BIT] = !cd1_s && !cd2_s; // RQ16
                        s_next.prdata[ST_WIDE_BIT] = !wide_s; // RQ15
                        s_next.prdata[ST_ACTIVE_BIT] = !activity_second_present_line_s; // RQ17
                        s_next.prdata[ST_DIAG_BIT] = !diag_s; // RQ18
                        s_next.prdata[ST_IRQ_BIT] = irq_s; // RQ12
                        s_next.prdata[ST_BADADDR_BIT] = s_reg.bad_addr;
                    end
                    LBA_OFF: s_next.prdata = {4'h0, s_reg.linear_block_number};
                    GEOM_OFF: s_next.prdata = {s_reg.spt, s_reg.heads, s_reg.cyl};
                    CAP_OFF: s_next.prdata = total_sectors; // RQ4
                    default: s_next.pslverr = 1'b1;
                endcase
            end
        end
        // card-side sequencer
        case (s_reg.phase)
            ST_IDLE: begin
                s_next.cmd_n = 1'b1;
                s_next.ctl_n = 1'b1;
            end
            ST_SETUP: begin
                // address and selects settle before the strobe
                s_next.sel = s_reg.code[2:0]; // RQ5
                s_next.cmd_n = s_reg.code[3]; // RQ7
                s_next.ctl_n = s_reg.code[4]; // RQ8
                s_next.bad_addr = (s_reg.code == CODE_SECNUM) && s_reg.is_write
                                  && (s_reg.wdata[7:0] == 8'h00);
                if (s_reg.code == CODE_DATA) begin
                    s_next.dout = s_reg.wdata; // RQ1 RQ10
                end else begin
                    s_next.dout = {8'h00, s_reg.wdata[7:0]}; // RQ10
                end
                s_next.doe = s_reg.is_write;
                if (s_reg.count != 16'h0000) begin
                    s_next.count = s_reg.count - 16'h0001;
                end else if (s_next.bad_addr) begin
                    s_next.phase = ST_IDLE; // RQ2
                    s_next.doe = 1'b0;
                end else begin
                    s_next.phase = ST_STROBE;
                    s_next.rd_n = s_reg.is_write; // RQ24
                    s_next.wr_n = !s_reg.is_write; // RQ24
                    s_next.count = 16'(SETUP_CYCLES);
                end
            end
            ST_STROBE: begin
                // hold strobe a minimum and until card reports ready
                if (s_reg.count != 16'h0000) begin
                    s_next.count = s_reg.count - 16'h0001;
                end else if (ready_s) begin // RQ14 RQ25
                    if (!s_reg.rd_n) begin
                        s_next.rdata = (s_reg.code == CODE_DATA) ? data_s
                                       : {8'h00, data_s[7:0]}; // RQ10 RQ22
                    end
                    s_next.rd_n = 1'b1;
                    s_next.wr_n = 1'b1;
                    s_next.phase = ST_RECOVER;
                    s_next.count = 16'(RECOVER_CYCLES);
                end
            end
            ST_RECOVER: begin
                s_next.doe = 1'b0;
                s_next.cmd_n = 1'b1;
                s_next.ctl_n = 1'b1;
                if (s_reg.count != 16'h0000) begin
                    s_next.count = s_reg.count - 16'h0001;
                end else begin
                    s_next.phase = ST_IDLE;
                end
            end
            ST_RESET: begin
                if (s_reg.count != 16'h0000) begin
                    s_next.count = s_reg.count - 16'h0001;
                end else begin
                    s_next.card_rst_n = 1'b1;
                    s_next.phase = ST_IDLE;
                end
            end
            default: begin
                s_next.phase = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
            s_reg.phase <= ST_IDLE;
            s_reg.cmd_n <= 1'b1;
            s_reg.ctl_n <= 1'b1;
            s_reg.rd_n <= 1'b1;
            s_reg.wr_n <= 1'b1;
            s_reg.card_rst_n <= 1'b0;
            s_reg.heads <= 8'h01;
            s_reg.spt <= 8'h01;
            s_reg.cyl <= 16'h0001;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin and bus outputs straight from flip-flops; upper address lines and fixed straps tied to constants
    assign prdata_out = s_reg.prdata;
    assign pready_out = s_reg.pready;
    assign pslverr_out = s_reg.pslverr;
    assign register_select_lines_out = s_reg.sel;
    assign upper_unused_address_lines_out = 8'h00; // RQ6
    assign command_group_select_n_out = s_reg.cmd_n;
    assign control_group_select_n_out = s_reg.ctl_n;
    assign read_strobe_n_out = s_reg.rd_n;
    assign write_strobe_n_out = s_reg.wr_n;
    assign card_data_lines_out = s_reg.dout;
    assign card_data_lines_oe_out = s_reg.doe;
    assign card_reset_n_out = s_reg.card_rst_n;
    assign interface_select_strap_out = 1'b0; // RQ11
    assign drive_position_strap_out = 1'b0; // RQ9
    assign attribute_select_n_out = 1'b1; // RQ19
    assign memory_write_enable_n_out = 1'b1; // RQ19
endmodule
`default_nettype wire

// File: ide_host_pkg.sv
package ide_host_pkg;
    // own register map, byte offsets on apb
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] ADDR_OFF = 8'h04;
    localparam logic [7:0] WDATA_OFF = 8'h08;
    localparam logic [7:0] RDATA_OFF = 8'h0C;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    localparam logic [7:0] LBA_OFF = 8'h14;
    localparam logic [7:0] GEOM_OFF = 8'h18;
    localparam logic [7:0] CAP_OFF = 8'h1C;
    // control register fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_RESET_BIT = 2;
    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PRESENT_BIT = 1;
    localparam int ST_WIDE_BIT = 2;
    localparam int ST_ACTIVE_BIT = 3;
    localparam int ST_DIAG_BIT = 4;
    localparam int ST_IRQ_BIT = 5;
    localparam int ST_BADADDR_BIT = 6;
    // access code fields: {ctl_sel_n, cmd_sel_n, a2, a1, a0}, selects given as pin levels
    localparam logic [4:0] CODE_DATA = 5'h10;
    localparam logic [4:0] CODE_SECCNT = 5'h12;
    localparam logic [4:0] CODE_SECNUM = 5'h13;
    localparam logic [4:0] CODE_STATUS = 5'h17;
    localparam logic [4:0] CODE_ALTSTATUS = 5'h0E;
    localparam int SECTOR_BYTES = 512;
    localparam int SECTOR_WORDS = SECTOR_BYTES / 2;
    localparam int SECCNT_ZERO_MEANS = 256;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int RESET_HOLD_US = 25;
    localparam int RESET_HOLD_CYCLES = RESET_HOLD_US * CLK_MHZ;
    localparam int SETUP_CYCLES = 2;
    localparam int RECOVER_CYCLES = 2;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// File: ide_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ide_sync import ide_host_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;
    sync_state_t state_reg;
    sync_state_t state_next;

    // two stage synchroniser; first stage feeds only the second
    always_comb begin
        state_next.first = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule
`default_nettype wire

// File: ide_geometry.sv
`timescale 1ns/1ps
`default_nettype none
module ide_geometry import ide_host_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] cyl_in,
    input wire logic [7:0] heads_in,
    input wire logic [7:0] spt_in,
    output logic [31:0] sectors_out,
    output logic [31:0] kbytes_out
);
    typedef struct packed {
        logic [31:0] sectors;
        logic [31:0] kbytes;
    } geom_state_t;
    geom_state_t state_reg;
    geom_state_t state_next;

    // total sectors = c*h*s; capacity = sectors*512, reported in kbytes by a one-bit shift
    always_comb begin
        state_next.sectors = {8'h00, 24'(cyl_in * heads_in)} * 32'(spt_in); // RQ4
        state_next.kbytes = {1'b0, state_reg.sectors[31:1]}; // RQ4
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sectors_out = state_reg.sectors;
    assign kbytes_out = state_reg.kbytes;
endmodule
`default_nettype wire

// File: ide_host_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ide_host_port_asserts import ide_host_pkg::*; (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [2:0] register_select_lines_out,
    input wire logic [7:0] upper_unused_address_lines_out,
    input wire logic command_group_select_n_out,
    input wire logic control_group_select_n_out,
    input wire logic read_strobe_n_out,
    input wire logic write_strobe_n_out,
    input wire logic card_ready_wait_in,
    input wire logic card_reset_n_out,
    input wire logic interface_select_strap_out,
    input wire logic attribute_select_n_out,
    input wire logic memory_write_enable_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    int low_cnt;
    logic strobing;
    // strobe activity and length of the card reset pulse
    assign strobing = !(read_strobe_n_out && write_strobe_n_out);
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= card_reset_n_out ? 0 : low_cnt + 1;
        end
    end
    sequence s_held;
        strobing [*3];
    endsequence
    a_upper_grounded: assert property (upper_unused_address_lines_out == 8'h00)
        else $error("upper address lines not low");
    a_ide_strap: assert property (interface_select_strap_out == 1'h0)
        else $error("interface select strap not low");
    a_unused_high: assert property (attribute_select_n_out && memory_write_enable_n_out)
        else $error("unused card inputs not high");
    a_reset_hold: assert property ($rose(card_reset_n_out) |-> low_cnt >= RESET_HOLD_CYCLES)
        else $error("card reset pulse too short");
    a_one_strobe: assert property (!(!read_strobe_n_out && !write_strobe_n_out))
        else $error("both strobes low");
    a_one_group: assert property (strobing |-> command_group_select_n_out != control_group_select_n_out)
        else $error("register group select wrong during strobe");
    a_code_stable: assert property (strobing |=> !strobing || $stable({register_select_lines_out,
        command_group_select_n_out, control_group_select_n_out}))
        else $error("access code moved during strobe");
    a_wait_ready: assert property (strobing && !card_ready_wait_in |=> strobing)
        else $error("strobe released while card not ready");
    a_strobe_min: assert property ($fell(read_strobe_n_out) || $fell(write_strobe_n_out) |-> s_held)
        else $error("strobe shorter than three cycles");
endmodule
bind ide_host_port ide_host_port_asserts chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .register_select_lines_out(register_select_lines_out),
    .upper_unused_address_lines_out(upper_unused_address_lines_out),
    .command_group_select_n_out(command_group_select_n_out),
    .control_group_select_n_out(control_group_select_n_out),
    .read_strobe_n_out(read_strobe_n_out), .write_strobe_n_out(write_strobe_n_out),
    .card_ready_wait_in(card_ready_wait_in), .card_reset_n_out(card_reset_n_out),
    .interface_select_strap_out(interface_select_strap_out),
    .attribute_select_n_out(attribute_select_n_out),
    .memory_write_enable_n_out(memory_write_enable_n_out));
`default_nettype wire

// File: ide_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module ide_card_model import ide_host_pkg::*; (
    input wire logic clk_in,
    input wire logic [2:0] sel_in,
    input wire logic cmd_n_in,
    input wire logic ctl_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [15:0] host_data_in,
    input wire logic [3:0] wait_in,
    output logic [15:0] data_out,
    output logic ready_out,
    output logic wide_n_out,
    output logic irq_out,
    output logic cd_n_out,
    output logic diag_n_out,
    output logic activity_second_present_line_n_out
);
    logic [15:0] regs [0:31] = '{default: 16'h0000};
    logic [15:0] last_q = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic pending = 1'h0;
    logic [4:0] code;
    logic [8:0] sectors_asked;
    // access code as seen on the pins
    assign code = {ctl_n_in, cmd_n_in, sel_in};
    // a zero sector count asks for the full 256 sectors
    assign sectors_asked = (regs[CODE_SECCNT][7:0] == 8'h00) ? 9'(SECCNT_ZERO_MEANS)
        : {1'b0, regs[CODE_SECCNT][7:0]};
    // latch writes at the end of the write strobe
    always @(posedge wr_n_in) begin
        regs[code] <= (code == CODE_DATA) ? host_data_in : {8'h00, host_data_in[7:0]};
        if (code == CODE_STATUS) pending <= 1'h1;
    end
    // only the primary status read clears the interrupt
    always @(posedge rd_n_in) begin
        if (code == CODE_STATUS) pending <= 1'h0;
    end
    // wait-state counter, released bus shows a changing pattern
    always @(posedge clk_in) begin
        last_q <= data_out;
        if (rd_n_in && wr_n_in) cnt <= wait_in;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    assign ready_out = (rd_n_in && wr_n_in) || cnt == 4'h0;
    assign wide_n_out = !(code == CODE_DATA && ready_out);
    assign irq_out = pending && !regs[CODE_ALTSTATUS][1];
    assign data_out = rd_n_in ? ~last_q : (code == CODE_STATUS || code == CODE_ALTSTATUS)
        ? 16'h0050 : regs[code];
    // fixed card pins: seated, diagnostics passed, single card 0
    assign cd_n_out = 1'h0;
    assign diag_n_out = 1'h0;
    assign activity_second_present_line_n_out = 1'h1;
endmodule
`default_nettype wire

// File: true_ide_card_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module true_ide_card_host_port_bench import ide_host_pkg::*;;
    logic clk = 1'h0;
    logic nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, upper;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] sel;
    logic cmd_n, ctl_n, rd_n, wr_n, oe, rdy, wide_n, irq, cd_n, diag_n, activity_second_present_line_n, creset_n;
    logic isel, dpos, attr_n, mwe_n;
    logic [15:0] hdata, mdata, bus;
    logic [3:0] wait_c;
    int errors = 0;
    int check_count = 0;
    assign bus = oe ? hdata : mdata;
    always #4 clk = ~clk;
    ide_host_port dut (.clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .register_select_lines_out(sel),
        .upper_unused_address_lines_out(upper), .command_group_select_n_out(cmd_n),
        .control_group_select_n_out(ctl_n), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
        .card_data_lines_in(bus), .card_data_lines_out(hdata), .card_data_lines_oe_out(oe),
        .card_ready_wait_in(rdy), .wide_port_indication_n_in(wide_n),
        .card_interrupt_request_in(irq), .card_detect_first_n_in(cd_n),
        .card_detect_second_n_in(cd_n), .diagnostics_passed_line_n_in(diag_n),
        .activity_second_present_line_n_in(activity_second_present_line_n), .card_reset_n_out(creset_n),
        .interface_select_strap_out(isel), .drive_position_strap_out(dpos),
        .attribute_select_n_out(attr_n), .memory_write_enable_n_out(mwe_n));
    ide_card_model card_m (.clk_in(clk), .sel_in(sel), .cmd_n_in(cmd_n), .ctl_n_in(ctl_n),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .host_data_in(bus), .wait_in(wait_c), .data_out(mdata),
        .ready_out(rdy), .wide_n_out(wide_n), .irq_out(irq), .cd_n_out(cd_n),
        .diag_n_out(diag_n), .activity_second_present_line_n_out(activity_second_present_line_n));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, waits for pready with a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 40);
        if (n >= 40) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // one card register access, then poll until not busy
    task automatic card(input logic [4:0] code, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        apb(1'h1, ADDR_OFF, {27'h0, code});
        apb(1'h1, WDATA_OFF, {16'h0, d});
        apb(1'h1, CTRL_OFF, {30'h0, w, 1'h1});
        do begin
            apb(1'h0, STATUS_OFF, ZERO32);
            n++;
        end while (rd[ST_BUSY_BIT] !== 1'h0 && n < 50);
        if (n >= 50) errors++;
    endtask
    task automatic t_pins;
        apb(1'h0, STATUS_OFF, ZERO32);
        check("present", 32'h1, rd[ST_PRESENT_BIT]);
        check("diag", 32'h1, rd[ST_DIAG_BIT]);
        check("active", 32'h0, rd[ST_ACTIVE_BIT]);
        check("straps", 32'h3, {upper, isel, dpos, attr_n, mwe_n});
        $display("test pins done");
    endtask
    task automatic t_reset;
        int n;
        n = 0;
        apb(1'h1, CTRL_OFF, 32'h4);
        while (creset_n !== 1'h1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        check("reset hold", 32'h1, n >= RESET_HOLD_CYCLES && n < 5000);
        $display("test card reset done");
    endtask
    task automatic t_regs;
        card(CODE_SECCNT, 1'h1, 16'hBEA5);
        check("seccnt", 32'hA5, card_m.regs[CODE_SECCNT]);
        card(CODE_SECCNT, 1'h1, 16'h0000);
        check("seccnt zero", SECCNT_ZERO_MEANS, card_m.sectors_asked);
        card(CODE_DATA, 1'h1, 16'h1234);
        check("data wr", 32'h1234, card_m.regs[CODE_DATA]);
        wait_c <= 4'h6;
        card(CODE_DATA, 1'h0, 16'h0000);
        apb(1'h0, RDATA_OFF, ZERO32);
        check("data rd", 32'h1234, rd[15:0]);
        wait_c <= 4'h0;
        card(CODE_SECNUM, 1'h1, 16'h0007);
        card(CODE_SECNUM, 1'h1, 16'h0000);
        check("secnum", 32'h7, card_m.regs[CODE_SECNUM]);
        apb(1'h0, STATUS_OFF, ZERO32);
        check("bad addr", 32'h1, rd[ST_BADADDR_BIT]);
        $display("test registers done");
    endtask
    task automatic t_irq;
        card(CODE_STATUS, 1'h1, 16'h0020);
        apb(1'h0, STATUS_OFF, ZERO32);
        check("irq set", 32'h1, rd[ST_IRQ_BIT]);
        card(CODE_ALTSTATUS, 1'h0, 16'h0000);
        apb(1'h0, RDATA_OFF, ZERO32);
        check("alt status", 32'h50, rd[7:0]);
        apb(1'h0, STATUS_OFF, ZERO32);
        check("irq kept", 32'h1, rd[ST_IRQ_BIT]);
        card(CODE_ALTSTATUS, 1'h1, 16'h0002);
        apb(1'h0, STATUS_OFF, ZERO32);
        check("irq masked", 32'h0, rd[ST_IRQ_BIT]);
        card(CODE_ALTSTATUS, 1'h1, 16'h0000);
        card(CODE_STATUS, 1'h0, 16'h0000);
        apb(1'h0, STATUS_OFF, ZERO32);
        check("irq cleared", 32'h0, rd[ST_IRQ_BIT]);
        $display("test interrupt done");
    endtask
    task automatic t_apb;
        apb(1'h1, GEOM_OFF, 32'h0504_0003);
        repeat (4) @(posedge clk);
        apb(1'h0, CAP_OFF, ZERO32);
        check("capacity", 32'h3C, rd);
        apb(1'h0, 8'hFC, ZERO32);
        check("unmapped", 32'h1, err);
        apb(1'h1, STATUS_OFF, ZERO32);
        check("ro write", 32'h1, err);
        apb(1'h1, LBA_OFF, 32'hFFFF_FFFF);
        apb(1'h0, LBA_OFF, ZERO32);
        check("lba", 32'h0FFF_FFFF, rd);
        apb(1'h1, CTRL_OFF, 32'h4);
        check("reset taken", 32'h0, err);
        apb(1'h1, CTRL_OFF, 32'h1);
        check("busy refused", 32'h1, err);
        $display("test apb done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // stimulus
    initial begin
        nrst = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = ZERO32;
        wait_c = 4'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        t_pins;
        t_reset;
        t_regs;
        t_irq;
        t_apb;
        finish_test;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test;
    end
endmodule
`default_nettype wire
